// ===== core/post_code_indicator.sv
// checkpoint capture, hex LED and LCD feed, and speaker beep-code sequencer
`timescale 1ns/100ps
module post_code_indicator #(
  parameter int unsigned BEEP_LEN = post_pkg::BEEP_CYC, // one beep, cycles
  parameter int unsigned GAP_LEN = post_pkg::GAP_CYC, // silence inside a burst
  parameter int unsigned PAUSE_LEN = post_pkg::PAUSE_CYC, // silence between groups
  parameter int unsigned LONG_LEN = post_pkg::LONG_CYC, // long beep
  parameter int unsigned TONE_HALF = post_pkg::TONE_HALF_CYC // tone half period
) (
  input wire logic clk_sys_in, // system clock, 40 MHz
  input wire logic rst_b_in, // async reset, active low
  input wire logic ce_in, // clock enable, freezes all state when low
  input wire logic io_wr_in, // host I/O write strobe
  input wire logic [15:0] io_addr_in, // host I/O address
  input wire logic [7:0] io_data_in, // host I/O write data
  input wire logic video_ready_in, // video display initialised
  input wire logic fault_in, // firmware reports failure at current checkpoint
  output logic [6:0] led_hi_seg_out, // upper hex digit segments
  output logic [6:0] led_lo_seg_out, // lower hex digit segments
  output logic [7:0] lcd_code_out, // checkpoint_code for front panel LCD
  output logic lcd_strobe_out, // new checkpoint_code pulse
  output logic speaker_out, // speaker drive
  output logic beep_busy_out // beep code in progress
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  post_pkg::beep_state_t state_q;
  logic hit;
  logic [6:0] hi_seg;
  logic [6:0] lo_seg;
  logic start_derived;
  logic start_rom;
  logic start_boot;
  logic start_any;
  logic [2:0] cnt_q [4];
  logic [2:0] ngroups_q;
  logic long_first_q;
  logic [1:0] grp_q;
  logic [2:0] left_q;
  logic [31:0] timer_q;
  logic [31:0] tone_run_q;
  logic phase_end;
  logic more_groups;
  logic tone_level;
  logic long_now;

  // timer load for the beep about to sound, its length in cycles minus one
  function automatic logic [31:0] tone_len(input logic is_long);
    tone_len = is_long ? 32'(LONG_LEN - 1) : 32'(BEEP_LEN - 1);
  endfunction : tone_len

  // ---------------------------------------------------------------
  // checkpoint capture
  // ---------------------------------------------------------------
  assign hit = ce_in && io_wr_in && (io_addr_in == post_pkg::CKPT_PORT_ADDR);

  hex_seg_decode u_dec_hi (
    .nibble_in(io_data_in[7:4]),
    .seg_out(hi_seg)
  );

  hex_seg_decode u_dec_lo (
    .nibble_in(io_data_in[3:0]),
    .seg_out(lo_seg)
  );

  // latch port write
  // digits are decoded at capture so the outputs stay plain flops
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      led_hi_seg_out <= post_pkg::SEG_RESET_VAL;
      led_lo_seg_out <= post_pkg::SEG_RESET_VAL;
    end else if (hit) begin
      led_hi_seg_out <= hi_seg;
      led_lo_seg_out <= lo_seg;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lcd_code_out <= post_pkg::CKPT_RESET_VAL;
      lcd_strobe_out <= 1'b0;
    end else if (ce_in) begin
      lcd_strobe_out <= hit;
      if (hit) begin
        lcd_code_out <= io_data_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // beep triggers
  // ---------------------------------------------------------------
  // gate on video state
  assign start_derived = ce_in && fault_in && !video_ready_in && post_pkg::is_error_code(lcd_code_out);
  assign start_rom = ce_in && fault_in && (lcd_code_out == post_pkg::CKPT_ROM_SCAN);
  assign start_boot = hit && (io_data_in == post_pkg::CKPT_BOOT);
  // a fault report restarts any sequence; a boot beep never cuts a fault code short
  assign start_any = start_derived || start_rom || (start_boot && state_q == post_pkg::ST_IDLE);

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < 4; i++) begin
        cnt_q[i] <= 3'h0;
      end
      ngroups_q <= 3'h0;
      long_first_q <= 1'b0;
    end else if (start_derived) begin
      for (int i = 0; i < 4; i++) begin
        cnt_q[i] <= post_pkg::group_beeps(lcd_code_out, 2'(i));
      end
      ngroups_q <= post_pkg::GROUPS_DERIVED;
      long_first_q <= 1'b0;
    end else if (start_rom) begin
      cnt_q[0] <= 3'h1;
      cnt_q[1] <= 3'h2;
      cnt_q[2] <= 3'h0;
      cnt_q[3] <= 3'h0;
      ngroups_q <= post_pkg::GROUPS_ROM;
      long_first_q <= 1'b1;
    end else if (start_any) begin
      cnt_q[0] <= 3'h1;
      cnt_q[1] <= 3'h0;
      cnt_q[2] <= 3'h0;
      cnt_q[3] <= 3'h0;
      ngroups_q <= post_pkg::GROUPS_BOOT;
      long_first_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  assign phase_end = ce_in && (timer_q == 32'h0000_0000);
  assign more_groups = ({1'b0, grp_q} + 3'h1) < ngroups_q;
  assign long_now = long_first_q && (grp_q == 2'h0);

  // start value of the first beep: long only for the option rom code
  function automatic logic first_long(input logic rom);
    first_long = rom;
  endfunction : first_long

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= post_pkg::ST_IDLE;
      grp_q <= 2'h0;
      left_q <= 3'h0;
      timer_q <= 32'h0000_0000;
    end else if (ce_in) begin
      if (start_any) begin
        state_q <= post_pkg::ST_TONE;
        grp_q <= 2'h0;
        left_q <= start_derived ? post_pkg::group_beeps(lcd_code_out, 2'h0) : 3'h1;
        timer_q <= tone_len(first_long(start_rom && !start_derived));
      end else begin
        case (state_q)
          post_pkg::ST_IDLE: begin
            timer_q <= 32'h0000_0000;
          end
          post_pkg::ST_TONE: begin
            if (phase_end) begin
              left_q <= left_q - 3'h1;
              if (left_q > 3'h1) begin
                state_q <= post_pkg::ST_GAP;
                timer_q <= 32'(GAP_LEN - 1);
              end else if (more_groups) begin
                state_q <= post_pkg::ST_PAUSE;
                timer_q <= 32'(PAUSE_LEN - 1);
              end else begin
                state_q <= post_pkg::ST_IDLE;
              end
            end else begin
              timer_q <= timer_q - 32'h0000_0001;
            end
          end
          post_pkg::ST_GAP: begin
            if (phase_end) begin
              state_q <= post_pkg::ST_TONE;
              timer_q <= tone_len(long_now);
            end else begin
              timer_q <= timer_q - 32'h0000_0001;
            end
          end
          post_pkg::ST_PAUSE: begin
            if (phase_end) begin
              state_q <= post_pkg::ST_TONE;
              grp_q <= grp_q + 2'h1;
              left_q <= cnt_q[grp_q + 2'h1];
              timer_q <= tone_len(1'b0);
            end else begin
              timer_q <= timer_q - 32'h0000_0001;
            end
          end
          default: begin
            state_q <= post_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // speaker drive
  // ---------------------------------------------------------------
  tone_gen #(
    .HALF_CYC(TONE_HALF)
  ) u_tone (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .en_in(state_q == post_pkg::ST_TONE),
    .level_out(tone_level)
  );

  // gate tone by state
  // speaker is silent outside TONE so gap and pause lengths are exact
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      speaker_out <= 1'b0;
      beep_busy_out <= 1'b0;
    end else if (ce_in) begin
      speaker_out <= (state_q == post_pkg::ST_TONE) && tone_level;
      beep_busy_out <= (state_q != post_pkg::ST_IDLE);
    end
  end

  // helper: cycles spent in the current beep, checked against BEEP_LEN for short beeps only
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tone_run_q <= 32'h0000_0000;
    end else if (ce_in) begin
      if (start_any || state_q != post_pkg::ST_TONE) begin
        tone_run_q <= 32'h0000_0000;
      end else begin
        tone_run_q <= tone_run_q + 32'h0000_0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  sequence tone_done_s;
    state_q == post_pkg::ST_TONE && phase_end && !start_any;
  endsequence

  sequence idle_fault_s;
    state_q == post_pkg::ST_IDLE && ce_in && fault_in && !hit;
  endsequence

  led_capture_a: assert property (hit |=> led_hi_seg_out == $past(hi_seg) && led_lo_seg_out == $past(lo_seg))
    else $error("led digits not updated from port write");

  lcd_feed_a: assert property (hit |=> lcd_strobe_out && lcd_code_out == $past(io_data_in))
    else $error("lcd copy or strobe missing");

  code_hold_a: assert property (ce_in && !hit |=> $stable(lcd_code_out) && !lcd_strobe_out)
    else $error("checkpoint changed without a write");

  group_split_a: assert property (start_derived |=> cnt_q[0] == {1'b0, $past(lcd_code_out[7:6])} + 3'h1
    && cnt_q[3] == {1'b0, $past(lcd_code_out[1:0])} + 3'h1 && ngroups_q == 3'h4)
    else $error("beep groups not split from checkpoint");

  burst_count_a: assert property (tone_done_s and (left_q > 3'h1) |=> state_q == post_pkg::ST_GAP)
    else $error("burst ended early");

  equal_beep_a: assert property (tone_done_s and !long_now |-> tone_run_q == 32'(BEEP_LEN - 1))
    else $error("beep length differs");

  group_pause_a: assert property (tone_done_s and (left_q == 3'h1) and more_groups
    |=> state_q == post_pkg::ST_PAUSE && timer_q == 32'(PAUSE_LEN - 1))
    else $error("group pause not entered");

  video_gate_a: assert property (idle_fault_s and video_ready_in and (lcd_code_out != post_pkg::CKPT_ROM_SCAN)
    |=> state_q == post_pkg::ST_IDLE)
    else $error("beep after video ready");

  error_only_a: assert property (idle_fault_s and !post_pkg::is_error_code(lcd_code_out)
    and (lcd_code_out != post_pkg::CKPT_ROM_SCAN) |=> state_q == post_pkg::ST_IDLE)
    else $error("beep on non-error checkpoint");

  rom_code_a: assert property (start_rom && !start_derived |=> long_first_q && ngroups_q == 3'h2
    && cnt_q[0] == 3'h1 && cnt_q[1] == 3'h2)
    else $error("option rom beep code wrong");

  boot_beep_a: assert property (start_boot && !fault_in && state_q == post_pkg::ST_IDLE
    |=> state_q == post_pkg::ST_TONE && ngroups_q == 3'h1 && left_q == 3'h1 && !long_first_q)
    else $error("boot beep not single short");

endmodule : post_code_indicator

// ===== pkg/post_pkg.sv
// constants, types and helpers shared by the checkpoint display and beep logic
// How it works
// - capture port 80h writes, show two hex digits
// - forward current checkpoint to front panel LCD
// - split checkpoint into four pairs, MSB first
// - each pair beeps its value plus one
// - all beeps of one derived code equal length
// - pause between groups longer than beep gap
// - derived codes beep only on faults before video ready
// - only listed error checkpoints sound derived codes
// - checkpoint 98 fault gives long then two
// - checkpoint B4 gives one short beep when no beep code is running
package post_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned BEEP_MS = 200;
  localparam int unsigned GAP_MS = 150;
  localparam int unsigned PAUSE_MS = 600;
  localparam int unsigned LONG_MS = 700;
  localparam int unsigned TONE_HZ = 1000;
  localparam int unsigned BEEP_CYC = BEEP_MS * CYC_PER_MS;
  localparam int unsigned GAP_CYC = GAP_MS * CYC_PER_MS;
  localparam int unsigned PAUSE_CYC = PAUSE_MS * CYC_PER_MS;
  localparam int unsigned LONG_CYC = LONG_MS * CYC_PER_MS;
  localparam int unsigned TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);

  // ---------------------------------------------------------------
  // checkpoint port and special codes
  // ---------------------------------------------------------------
  localparam logic [15:0] CKPT_PORT_ADDR = 16'h0080;
  localparam logic [7:0] CKPT_RESET_VAL = 8'h00;
  localparam logic [7:0] CKPT_ROM_SCAN = 8'h98;
  localparam logic [7:0] CKPT_BOOT = 8'hB4;
  localparam logic [2:0] GROUPS_DERIVED = 3'h4;
  localparam logic [2:0] GROUPS_ROM = 3'h2;
  localparam logic [2:0] GROUPS_BOOT = 3'h1;
  localparam logic [6:0] SEG_RESET_VAL = 7'h3F;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TONE = 2'b01,
    ST_GAP = 2'b10,
    ST_PAUSE = 2'b11
  } beep_state_t;

  // checkpoints that own an error condition with a derived beep code
  function automatic logic is_error_code(input logic [7:0] code);
    case (code)
      8'h16, 8'h20, 8'h22, 8'h28, 8'h2C, 8'h46, 8'h58: is_error_code = 1'b1;
      default: is_error_code = 1'b0;
    endcase
  endfunction : is_error_code

  // beep count of one 2-bit group, made one-based
  function automatic logic [2:0] group_beeps(input logic [7:0] code, input logic [1:0] idx);
    logic [1:0] pair;
    pair = code[7 - 2 * idx -: 2];
    group_beeps = {1'b0, pair} + 3'h1;
  endfunction : group_beeps

endpackage : post_pkg

// ===== core/hex_seg_decode.sv
// hex nibble to seven-segment pattern, segments g..a, active high
`timescale 1ns/100ps
module hex_seg_decode (
  input wire logic [3:0] nibble_in, // hex digit
  output logic [6:0] seg_out // segment pattern gfedcba
);

  // ---------------------------------------------------------------
  // lookup
  // ---------------------------------------------------------------
  // plain table keeps the two digits identical in timing
  always_comb begin
    case (nibble_in)
      4'h0: seg_out = 7'h3F;
      4'h1: seg_out = 7'h06;
      4'h2: seg_out = 7'h5B;
      4'h3: seg_out = 7'h4F;
      4'h4: seg_out = 7'h66;
      4'h5: seg_out = 7'h6D;
      4'h6: seg_out = 7'h7D;
      4'h7: seg_out = 7'h07;
      4'h8: seg_out = 7'h7F;
      4'h9: seg_out = 7'h6F;
      4'hA: seg_out = 7'h77;
      4'hB: seg_out = 7'h7C;
      4'hC: seg_out = 7'h39;
      4'hD: seg_out = 7'h5E;
      4'hE: seg_out = 7'h79;
      default: seg_out = 7'h71;
    endcase
  end

endmodule : hex_seg_decode

// ===== core/tone_gen.sv
// square-wave tone source for the speaker, runs only while enabled
`timescale 1ns/100ps
module tone_gen #(
  parameter int unsigned HALF_CYC = post_pkg::TONE_HALF_CYC
) (
  input wire logic clk_sys_in, // system clock
  input wire logic rst_b_in, // async reset, active low
  input wire logic ce_in, // clock enable
  input wire logic en_in, // tone wanted
  output logic level_out // tone square wave
);

  logic [31:0] div_q;

  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  // restarting on each enable gives every beep the same waveform phase
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_q <= 32'h0000_0000;
      level_out <= 1'b0;
    end else if (ce_in) begin
      if (!en_in) begin
        div_q <= 32'h0000_0000;
        level_out <= 1'b0;
      end else if (div_q == HALF_CYC - 1) begin
        div_q <= 32'h0000_0000;
        level_out <= !level_out;
      end else begin
        div_q <= div_q + 32'h0000_0001;
      end
    end
  end

endmodule : tone_gen

// ===== tb/host_fw_model.sv
// host firmware model: checkpoint writes, failure reports and video state
`timescale 1ns/100ps
module host_fw_model (
  input wire logic clk_sys_in, // system clock
  output logic io_wr_out, // i/o write strobe
  output logic [15:0] io_addr_out, // i/o address
  output logic [7:0] io_data_out, // write data
  output logic video_ready_out, // video initialised
  output logic fault_out // failure at current checkpoint
);
  // ----------------------------------------
  // host side drivers
  // ----------------------------------------
  // idle bus at time zero
  initial begin
    io_wr_out = 1'b0;
    io_addr_out = 16'hFFFF;
    io_data_out = 8'h00;
    video_ready_out = 1'b0;
    fault_out = 1'b0;
  end
  // phase code writes
  // n codes back to back, data counting up; bus scrambled after so stale values never match
  task automatic write_code(input logic [15:0] addr, input logic [7:0] data, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys_in);
      #1;
      io_wr_out = 1'b1;
      io_addr_out = addr;
      io_data_out = data + 8'(i);
    end
    @(posedge clk_sys_in);
    #1;
    io_wr_out = 1'b0;
    io_addr_out = ~addr;
    io_data_out = ~io_data_out;
  endtask : write_code
  // one-cycle failure report; the caller goes on writing codes after 28 and 2C
  task automatic report_fault();
    @(posedge clk_sys_in);
    #1;
    fault_out = 1'b1;
    @(posedge clk_sys_in);
    #1;
    fault_out = 1'b0;
  endtask : report_fault
  // video state changes off the edge like every other input
  task automatic set_video(input logic v);
    @(posedge clk_sys_in);
    #1;
    video_ready_out = v;
  endtask : set_video
endmodule : host_fw_model

// ===== tb/post_code_beep_indicator_tb.sv
// testbench for the checkpoint indicator: display feed and beep codes
`timescale 1ns/100ps
module post_code_beep_indicator_tb;
  // short durations keep the run small; even lengths keep tone phase alike per beep
  localparam int unsigned BEEP_LEN = 8;
  localparam int unsigned GAP_LEN = 4;
  localparam int unsigned PAUSE_LEN = 16;
  localparam int unsigned LONG_LEN = 16;
  localparam int unsigned TONE_HALF = 1;
  localparam logic [6:0] SEG [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
    7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic ce_in = 1'b1;
  logic io_wr, video_ready, fault_rep, lcd_strobe, speaker, busy;
  logic [15:0] io_addr;
  logic [7:0] io_data, lcd_code;
  logic [6:0] led_hi, led_lo;
  logic [15:0] heard; // group counts, one nibble each, first group highest
  logic heard_long; // a beep longer than a short one was heard
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int span_dev, first, max_gap, min_pause;

  host_fw_model host_fw_model_i (.clk_sys_in(clk_sys_in), .io_wr_out(io_wr), .io_addr_out(io_addr),
    .io_data_out(io_data), .video_ready_out(video_ready), .fault_out(fault_rep));
  post_code_indicator #(.BEEP_LEN(BEEP_LEN), .GAP_LEN(GAP_LEN), .PAUSE_LEN(PAUSE_LEN),
    .LONG_LEN(LONG_LEN), .TONE_HALF(TONE_HALF)) post_code_indicator_i (.clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in), .ce_in(ce_in), .io_wr_in(io_wr), .io_addr_in(io_addr), .io_data_in(io_data),
    .video_ready_in(video_ready), .fault_in(fault_rep), .led_hi_seg_out(led_hi), .led_lo_seg_out(led_lo),
    .lcd_code_out(lcd_code), .lcd_strobe_out(lcd_strobe), .speaker_out(speaker), .beep_busy_out(busy));

  // ----------------------------------------
  // clock, watchdog and helpers
  // ----------------------------------------
  always #12.5 clk_sys_in = ~clk_sys_in;
  // a hang is cut short at 10000 cycles, well past the under 2000 cycles the run needs
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check
  // each 2-bit pair plus one, one nibble per group
  function automatic logic [15:0] derive(input logic [7:0] c);
    derive = {2'b00, c[7:6], 2'b00, c[5:4], 2'b00, c[3:2], 2'b00, c[1:0]} + 16'h1111;
  endfunction : derive
  task automatic note_span(input int s);
    if (s > 11) heard_long = 1'b1;
    else if (first < 0) first = s;
    else if ((s > first ? s - first : first - s) > span_dev) span_dev = s > first ? s - first : first - s;
  endtask : note_span
  // beeps found from speaker activity: short silence inside a tone, gap 3+, group pause 10+
  task automatic listen();
    int z, t, hi0, hi1, grp, n;
    heard = 16'h0000;
    heard_long = 1'b0;
    span_dev = 0;
    first = -1;
    max_gap = 0;
    min_pause = 999;
    z = 99;
    grp = 0;
    n = 0;
    hi0 = 0;
    hi1 = 0;
    for (t = 0; t < 3000 && (busy === 1'b1 || t < 8); t++) begin
      @(posedge clk_sys_in);
      #2;
      if (speaker === 1'b1) begin
        if (z >= 3) begin
          if (n > 0) note_span(hi1 - hi0);
          if (z >= 10 && n > 0) begin
            heard = {heard[11:0], 4'(grp)};
            grp = 0;
            min_pause = z < min_pause ? z : min_pause;
          end else if (n > 0) begin
            max_gap = z > max_gap ? z : max_gap;
          end
          grp++;
          n++;
          hi0 = t;
        end
        hi1 = t;
        z = 0;
      end else begin
        z++;
      end
    end
    if (n > 0) note_span(hi1 - hi0);
    heard = {heard[11:0], 4'(grp)};
  endtask : listen
  task automatic quiet(output int loud);
    loud = 0;
    repeat (30) begin
      @(posedge clk_sys_in);
      #2;
      if (busy !== 1'b0 || speaker !== 1'b0) loud++;
    end
  endtask : quiet
  task automatic check_cleared();
    check(lcd_code, 8'h00, "lcd cleared");
    check({led_hi, led_lo}, {SEG[0], SEG[0]}, "digits cleared");
    check({lcd_strobe, speaker, busy}, 3'b000, "quiet outputs");
  endtask : check_cleared

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_display();
    logic [7:0] codes [8] = '{8'h4B, 8'h02, 8'hE7, 8'hD9, 8'h5F, 8'h36, 8'h8A, 8'hC1};
    foreach (codes[k]) begin
      host_fw_model_i.write_code(16'h0080, codes[k], 1);
      check(lcd_code, codes[k], "lcd code");
      check(lcd_strobe, 1'b1, "lcd strobe");
      check({led_hi, led_lo}, {SEG[codes[k][7:4]], SEG[codes[k][3:0]]}, "hex digits");
      @(posedge clk_sys_in);
      #1;
      check(lcd_strobe, 1'b0, "strobe width");
    end
    host_fw_model_i.write_code(16'h0080, 8'h3C, 3);
    check(lcd_code, 8'h3E, "last write wins");
    check(led_lo, SEG[14], "last digit");
  endtask : t_display
  task automatic t_refuse();
    host_fw_model_i.write_code(16'h0081, 8'h55, 1);
    check({lcd_strobe, lcd_code}, {1'b0, 8'h3E}, "other address");
    ce_in = 1'b0;
    host_fw_model_i.write_code(16'h0080, 8'h66, 1);
    ce_in = 1'b1;
    repeat (20) @(posedge clk_sys_in);
    #1;
    check({led_hi, lcd_code}, {SEG[3], 8'h3E}, "held code");
  endtask : t_refuse
  task automatic t_derived();
    logic [7:0] errs [7] = '{8'h16, 8'h20, 8'h22, 8'h28, 8'h2C, 8'h46, 8'h58};
    foreach (errs[k]) begin
      host_fw_model_i.write_code(16'h0080, errs[k], 1);
      host_fw_model_i.report_fault();
      listen();
      check(heard, derive(errs[k]), "beep code");
      check({heard_long, span_dev <= 1}, 2'b01, "equal beeps");
      // half-period 1 tone: first and last high sample of a beep lie BEEP_LEN-2 apart
      check(first, BEEP_LEN - 2, "beep length");
      check(min_pause > max_gap, 1'b1, "group pause");
      check(lcd_code, errs[k], "final code");
    end
  endtask : t_derived
  task automatic t_suppress();
    int loud;
    host_fw_model_i.set_video(1'b1);
    host_fw_model_i.write_code(16'h0080, 8'h20, 1);
    host_fw_model_i.report_fault();
    quiet(loud);
    check(loud, 0, "video up, silent");
    host_fw_model_i.set_video(1'b0);
    host_fw_model_i.write_code(16'h0080, 8'h4B, 1);
    host_fw_model_i.report_fault();
    quiet(loud);
    check(loud, 0, "plain code, silent");
  endtask : t_suppress
  task automatic t_special();
    host_fw_model_i.set_video(1'b1);
    host_fw_model_i.write_code(16'h0080, 8'h98, 1);
    host_fw_model_i.report_fault();
    listen();
    check({heard_long, heard}, {1'b1, 16'h0012}, "long then two");
    host_fw_model_i.set_video(1'b0);
    host_fw_model_i.write_code(16'h0080, 8'hB4, 1);
    listen();
    check({heard_long, heard}, {1'b0, 16'h0001}, "boot beep");
  endtask : t_special
  task automatic t_overlap();
    host_fw_model_i.write_code(16'h0080, 8'h46, 1);
    host_fw_model_i.report_fault();
    repeat (20) @(posedge clk_sys_in);
    // second report lands in the first group pause and must restart from group one
    host_fw_model_i.report_fault();
    listen();
    check(heard, derive(8'h46), "restarted code");
    host_fw_model_i.write_code(16'h0080, 8'h20, 1);
    host_fw_model_i.report_fault();
    // a boot write during the pause must not cut the running fault code short
    fork
      listen();
      begin
        repeat (10) @(posedge clk_sys_in);
        host_fw_model_i.write_code(16'h0080, 8'hB4, 1);
      end
    join
    check(heard, derive(8'h20), "boot write while busy");
    check(lcd_code, 8'hB4, "code shown while beeping");
  endtask : t_overlap
  task automatic t_abort();
    int loud;
    host_fw_model_i.write_code(16'h0080, 8'h58, 1);
    host_fw_model_i.report_fault();
    repeat (30) @(posedge clk_sys_in);
    #1;
    check(busy, 1'b1, "code running");
    rst_b_in = 1'b0;
    #2;
    check_cleared();
    @(posedge clk_sys_in);
    #1;
    rst_b_in = 1'b1;
    @(posedge clk_sys_in);
    #1;
    check_cleared();
    quiet(loud);
    check(loud, 0, "code aborted");
  endtask : t_abort
  task automatic end_of_test();
    $display("checks run %0d, failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys_in);
    #1;
    rst_b_in = 1'b1;
    check_cleared();
    t_display();
    t_refuse();
    t_derived();
    t_suppress();
    t_special();
    t_overlap();
    t_abort();
    end_of_test();
  end
endmodule : post_code_beep_indicator_tb
